// file: inc/mmd_cfg.svh
// Notes on behaviour
// - Three-bit partition field splits flash; 111 is all program, data flash starts 0400.
// - Program space shrinks from top; fetches above it go to external memory.
// - 1024-byte data SRAM sits at data address 0, data flash directly above it.
// - Write-select bit in register 8Fh lets data moves reach program-configured flash.
// - Fetches never execute from the flash region assigned to data memory.
// - Lock bit blocks program flash write/erase; data flash stays fully usable.
// - Flash is erased in 128-byte pages; software erases a page before writing.
// - Internal data accesses never show their data on the low address/data port.
// - 64kB data space plus a separate 256-byte scratchpad reached by register access.
// - Direct addresses 80h-FFh are special registers, 00h-7Fh lower scratchpad.
// - Indirect references to 128-255 reach upper scratchpad, not special registers.
// - Bytes 20h-2Fh give 128 bits; bit n lives in byte 20h+n/8, bit n%8.
// - Special register bits exist only at addresses ending in hex 0 or 8.
// - Bit versus byte access is chosen by instruction type, never by address.
// - Four banks of eight working registers at 00h, 08h, 10h, 18h.
// - Working register references use the bank chosen in status word at D0h.
// - Working registers 0 and 1 act as indirect pointers, upper scratchpad included.
// - Partition configuration changes only in flash programming mode.
// - Accesses beyond internal memory go out through the external address/data port.
//
// Holds the address map and reset values of the memory map decoder.
// Assumes inclusion by bare name from the design.
`ifndef MMD_CFG_SVH
`define MMD_CFG_SVH
`define MMD_MWS_ADDR    8'h8F
`define MMD_PSW_ADDR    8'hD0
`define MMD_MWS_RESET   8'h00
`define MMD_PSW_RESET   8'h00
`define MMD_FLASH_MOVE_WRITE_SELECT_BIT_BIT    0
`define MMD_RS_LSB      3
`define MMD_HCF_RESET   4'h7
`define MMD_HCF_LOCK    3
`define MMD_SRAM_TOP    17'h0_0400
`define MMD_DF_BASE     17'h0_0400
`define MMD_FLASH_SIZE  17'h0_8000
`define MMD_BIT_BASE    8'h20
`define MMD_PAGE_LSB    7
`define MMD_SFR_LOW     8'h80
`endif

// file: inc/mmd_pkg.sv
// Types shared by the memory map decoder.
// Assumes the constants header sits in the include path.
package mmd_pkg;
    typedef enum logic [2:0] {
        MMD_T_NONE,
        MMD_T_SRAM,
        MMD_T_DFLASH,
        MMD_T_PFLASH,
        MMD_T_EXT
    } mmd_tgt_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        erase;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mmd_xreq_t;

    typedef struct packed {
        logic       valid;
        logic       indirect;
        logic       bit_op;
        logic       wreg;
        logic [7:0] addr;
    } mmd_rreq_t;
endpackage

// file: rtl/mmd_decoder.sv
// Memory map decoder: program, data and register space target selection.
// Assumes the core presents one request per cycle and the memories answer it.
`include "mmd_cfg.svh"
module mmd_decoder
    import mmd_pkg::*;
(
    input  wire logic        mclk,          // Core clock
    input  wire logic        nrst,          // Sync reset, active low
    input  wire logic        prog_mode_pin, // Flash programming mode pin
    input  wire logic        cfg_we,        // Config write strobe
    input  wire logic [3:0]  cfg_wdata,     // Lock bit and partition field
    input  wire logic        fetch_valid,   // Instruction fetch request
    input  wire logic [15:0] fetch_addr,    // Program counter
    input  wire mmd_xreq_t   xreq,          // Data move request
    input  wire mmd_rreq_t   rreq,          // Register space request
    input  wire logic        sfr_we,        // Register write, byte or bit
    input  wire logic [7:0]  sfr_wdata,     // Register write data
    output mmd_tgt_t         fetch_tgt,     // Fetch target
    output mmd_tgt_t         x_tgt,         // Data move target
    output logic [15:0]      x_mem_addr,    // Offset inside target
    output logic             x_denied,      // Write/erase refused
    output logic [8:0]       erase_page,    // Page of an erase
    output logic             ram_sel,       // Scratchpad selected
    output logic             sfr_sel,       // Special register selected
    output logic [7:0]       byte_addr,     // Resolved byte address
    output logic [2:0]       bit_pos,       // Bit inside byte
    output logic             bit_ok,        // Bit access legal
    output logic [7:0]       ptr_addr,      // Bank address of pointer reg
    output logic [7:0]       sfr_rdata_q,   // Internal register read data
    output logic [7:0]       adlo_q,        // Low address/data port data
    output logic             adlo_oe_q,     // Port drives data phase
    output logic [3:0]       hw_config_q    // Lock bit and partition
);
    //--------------------------------------------------
    // Partition arithmetic
    //--------------------------------------------------
    // Bytes of program flash for a partition code
    function automatic logic [16:0] pm_bytes(input logic [2:0] c);
        unique case (c)
            3'b111:  pm_bytes = 17'h0_8000;
            3'b110:  pm_bytes = 17'h0_7C00;
            3'b101:  pm_bytes = 17'h0_7800;
            3'b100:  pm_bytes = 17'h0_7000;
            3'b011:  pm_bytes = 17'h0_6000;
            3'b010:  pm_bytes = 17'h0_4000;
            default: pm_bytes = 17'h0_0000;
        endcase
    endfunction

    logic       prog_s1_q;
    logic       prog_s2_q;
    logic [7:0] mws_q;
    logic [7:0] psw_q;
    logic [16:0] pm_top;
    logic [16:0] df_end;
    logic [16:0] xa;
    logic        flash_move_write_select_bit;
    logic        lock;

    assign pm_top = pm_bytes(hw_config_q[2:0]);
    assign df_end = `MMD_DF_BASE + (`MMD_FLASH_SIZE - pm_top);
    assign xa     = {1'b0, xreq.addr};
    assign flash_move_write_select_bit   = mws_q[`MMD_FLASH_MOVE_WRITE_SELECT_BIT_BIT];
    assign lock   = hw_config_q[`MMD_HCF_LOCK];

    //--------------------------------------------------
    // Programming mode pin and configuration
    //--------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            prog_s1_q <= 1'b0;
            prog_s2_q <= 1'b0;
        end else begin
            prog_s1_q <= prog_mode_pin;
            prog_s2_q <= prog_s1_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hw_config_q <= `MMD_HCF_RESET;
        end else if (cfg_we && prog_s2_q) begin
            hw_config_q <= cfg_wdata;
        end
    end

    //--------------------------------------------------
    // Program space
    //--------------------------------------------------
    always_comb begin
        fetch_tgt = MMD_T_NONE;
        if (fetch_valid) begin
            // Flash above the program top belongs to data; such fetches leave the chip
            if ({1'b0, fetch_addr} < pm_top) begin
                fetch_tgt = MMD_T_PFLASH;
            end else begin
                fetch_tgt = MMD_T_EXT;
            end
        end
    end

    //--------------------------------------------------
    // Data space
    //--------------------------------------------------
    always_comb begin
        x_tgt      = MMD_T_NONE;
        x_mem_addr = xreq.addr;
        x_denied   = 1'b0;
        if (xreq.valid) begin
            if (flash_move_write_select_bit && xa < pm_top) begin
                x_tgt    = MMD_T_PFLASH;
                x_denied = (xreq.write || xreq.erase) && lock;
            end else if (xa < `MMD_SRAM_TOP) begin
                x_tgt = MMD_T_SRAM;
            end else if (xa < df_end) begin
                x_tgt      = MMD_T_DFLASH;
                x_mem_addr = xreq.addr - 16'h0400;
            end else begin
                x_tgt = MMD_T_EXT;
            end
        end
    end

    assign erase_page = xreq.addr[15:`MMD_PAGE_LSB];

    //--------------------------------------------------
    // Register space
    //--------------------------------------------------
    always_comb begin
        ram_sel   = 1'b0;
        sfr_sel   = 1'b0;
        byte_addr = rreq.addr;
        bit_pos   = 3'h0;
        bit_ok    = 1'b0;
        if (rreq.valid) begin
            if (rreq.wreg) begin
                byte_addr = {3'b000, psw_q[`MMD_RS_LSB +: 2], rreq.addr[2:0]};
                ram_sel   = 1'b1;
            end else if (rreq.bit_op) begin
                bit_pos = rreq.addr[2:0];
                bit_ok  = 1'b1;
                if (rreq.addr[7]) begin
                    byte_addr = {rreq.addr[7:3], 3'b000};
                    sfr_sel   = 1'b1;
                end else begin
                    byte_addr = `MMD_BIT_BASE + {4'h0, rreq.addr[6:3]};
                    ram_sel   = 1'b1;
                end
            end else if (rreq.indirect) begin
                ram_sel = 1'b1;
            end else if (rreq.addr >= `MMD_SFR_LOW) begin
                sfr_sel = 1'b1;
            end else begin
                ram_sel = 1'b1;
            end
        end
    end

    // Scratchpad address of pointer register 0 or 1 in the current bank
    assign ptr_addr = {3'b000, psw_q[`MMD_RS_LSB +: 2], 2'b00, rreq.addr[0]};

    //--------------------------------------------------
    // Internal special registers
    //--------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mws_q <= `MMD_MWS_RESET;
        end else if (sfr_we && sfr_sel && byte_addr == `MMD_MWS_ADDR && !bit_ok) begin
            mws_q <= sfr_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            psw_q <= `MMD_PSW_RESET;
        end else if (sfr_we && sfr_sel && byte_addr == `MMD_PSW_ADDR) begin
            if (bit_ok) begin
                psw_q[bit_pos] <= sfr_wdata[0];
            end else begin
                psw_q <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_sel && byte_addr == `MMD_MWS_ADDR) begin
            sfr_rdata_q <= mws_q;
        end else if (sfr_sel && byte_addr == `MMD_PSW_ADDR) begin
            sfr_rdata_q <= psw_q;
        end else begin
            sfr_rdata_q <= 8'h00;
        end
    end

    //--------------------------------------------------
    // Low address/data port, data phase
    //--------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            adlo_q    <= 8'h00;
            adlo_oe_q <= 1'b0;
        end else if (xreq.valid && xreq.write && x_tgt == MMD_T_EXT) begin
            adlo_q    <= xreq.wdata;
            adlo_oe_q <= 1'b1;
        end else begin
            adlo_q    <= 8'h00;
            adlo_oe_q <= xreq.valid;
        end
    end

    //--------------------------------------------------
    // Checks
    //--------------------------------------------------
    sequence s_int_access;
        xreq.valid && x_tgt != MMD_T_EXT;
    endsequence

    sequence s_port_quiet;
        adlo_q == 8'h00;
    endsequence

    a_port_hidden: assert property (@(posedge mclk) disable iff (!nrst)
        s_int_access |=> s_port_quiet) else $error("internal data shown on port");

    a_fetch_top: assert property (@(posedge mclk) disable iff (!nrst)
        fetch_valid && {1'b0, fetch_addr} >= pm_top |-> fetch_tgt == MMD_T_EXT)
        else $error("fetch above program top kept internal");

    a_no_exec_data: assert property (@(posedge mclk) disable iff (!nrst)
        fetch_tgt == MMD_T_PFLASH |-> {1'b0, fetch_addr} < pm_top)
        else $error("fetch from data flash region");

    a_sram_low: assert property (@(posedge mclk) disable iff (!nrst)
        xreq.valid && !flash_move_write_select_bit && xreq.addr < 16'h0400 |-> x_tgt == MMD_T_SRAM)
        else $error("low data address missed sram");

    a_default_part: assert property (@(posedge mclk) disable iff (!nrst)
        hw_config_q[2:0] == 3'b111 && xreq.valid && !flash_move_write_select_bit && xreq.addr >= 16'h0400
        |-> x_tgt == MMD_T_EXT) else $error("data flash present in default split");

    a_lock_guard: assert property (@(posedge mclk) disable iff (!nrst)
        x_tgt == MMD_T_DFLASH |-> !x_denied) else $error("data flash access refused");

    a_cfg_frozen: assert property (@(posedge mclk) disable iff (!nrst)
        !prog_s2_q |=> $stable(hw_config_q)) else $error("config changed outside programming");

    a_direct_sfr: assert property (@(posedge mclk) disable iff (!nrst)
        rreq.valid && !rreq.indirect && !rreq.bit_op && !rreq.wreg && rreq.addr[7]
        |-> sfr_sel && !ram_sel) else $error("direct high address not special register");

    a_upper_ram: assert property (@(posedge mclk) disable iff (!nrst)
        rreq.valid && rreq.indirect && !rreq.bit_op && !rreq.wreg |-> ram_sel && !sfr_sel)
        else $error("indirect reference reached special register");

    a_bit_sfr: assert property (@(posedge mclk) disable iff (!nrst)
        bit_ok && sfr_sel |-> byte_addr[2:0] == 3'b000) else $error("bit of non-aligned register");

    a_bit_ram: assert property (@(posedge mclk) disable iff (!nrst)
        bit_ok && ram_sel |-> byte_addr >= 8'h20 && byte_addr <= 8'h2F)
        else $error("ram bit outside bit area");

    a_bank_map: assert property (@(posedge mclk) disable iff (!nrst)
        rreq.valid && rreq.wreg |-> byte_addr[4:3] == psw_q[4:3] && byte_addr[7:5] == 3'b000)
        else $error("working register in wrong bank");

    a_mws_effect: assert property (@(posedge mclk) disable iff (!nrst)
        xreq.valid && flash_move_write_select_bit && {1'b0, xreq.addr} < pm_top |-> x_tgt == MMD_T_PFLASH)
        else $error("write select ignored");
endmodule

// file: dv/mmd_core_model.sv
// Core model: issues fetch, data move and register requests.
// Assumes the bench calls its tasks; requests change at the falling edge.
module mmd_core_model
    import mmd_pkg::*;
(
    input  wire logic        mclk,        // Core clock
    output logic             fetch_valid, // Fetch request
    output logic [15:0]      fetch_addr,  // Program counter
    output mmd_xreq_t        xreq,        // Data move request
    output mmd_rreq_t        rreq,        // Register request
    output logic             sfr_we,      // Register write
    output logic [7:0]       sfr_wdata    // Register write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fetch_valid = 1'h0;
        fetch_addr  = 16'h0000;
        xreq        = '0;
        rreq        = '0;
        sfr_we      = 1'h0;
        sfr_wdata   = 8'h00;
    end
    // Released strobes go low and address/data lines carry the inverse of their last value; the group about to be driven is left alone
    task automatic clear(int keep);
        if (keep != 0) begin
            fetch_valid = 1'h0;
            fetch_addr  = ~fetch_addr;
        end
        if (keep != 1) begin
            xreq = '{valid: 1'h0, write: 1'h0, erase: 1'h0, addr: ~xreq.addr, wdata: ~xreq.wdata};
        end
        if (keep != 2) begin
            rreq      = '{valid: 1'h0, indirect: 1'h0, bit_op: 1'h0, wreg: 1'h0, addr: ~rreq.addr};
            sfr_we    = 1'h0;
            sfr_wdata = ~sfr_wdata;
        end
    endtask
    task automatic fetch(logic [15:0] a);
        @(negedge mclk);
        clear(0);
        fetch_valid = 1'h1;
        fetch_addr  = a;
    endtask
    // The bench erases the page at 0480h before it writes there; its writes to 1000h and 0500h have no erase first
    task automatic xmove(logic w, logic e, logic [15:0] a, logic [7:0] d);
        @(negedge mclk);
        clear(1);
        xreq = '{valid: 1'h1, write: w, erase: e, addr: a, wdata: d};
    endtask
    task automatic reg_req(logic ind, logic bo, logic wr, logic [7:0] a, logic we, logic [7:0] d);
        @(negedge mclk);
        clear(2);
        rreq      = '{valid: 1'h1, indirect: ind, bit_op: bo, wreg: wr, addr: a};
        sfr_we    = we;
        sfr_wdata = d;
    endtask
endmodule

// file: dv/mmd_decoder_tb.sv
// Self-checking bench for the memory map decoder.
// Assumes the core model drives requests; the bench drives reset and config.
module mmd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mmd_pkg::*;
    logic        mclk, nrst, prog_mode_pin, cfg_we, fetch_valid, sfr_we;
    logic        x_denied, ram_sel, sfr_sel, bit_ok, adlo_oe_q;
    logic [3:0]  cfg_wdata, hw_config_q;
    logic [15:0] fetch_addr, x_mem_addr;
    logic [7:0]  sfr_wdata, byte_addr, ptr_addr, sfr_rdata_q, adlo_q;
    logic [8:0]  erase_page;
    logic [2:0]  bit_pos;
    mmd_xreq_t   xreq;
    mmd_rreq_t   rreq;
    mmd_tgt_t    fetch_tgt, x_tgt;
    int          bad_count = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    localparam logic [15:0] TOPS [8] = '{16'h0000, 16'h0000, 16'h4000, 16'h6000,
                                         16'h7000, 16'h7800, 16'h7C00, 16'h8000};
    mmd_core_model mmd_core_model_i (.mclk(mclk), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .xreq(xreq), .rreq(rreq), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata));
    mmd_decoder mmd_decoder_i (.mclk(mclk), .nrst(nrst), .prog_mode_pin(prog_mode_pin), .cfg_we(cfg_we),
        .cfg_wdata(cfg_wdata), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .xreq(xreq),
        .rreq(rreq), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata), .fetch_tgt(fetch_tgt), .x_tgt(x_tgt),
        .x_mem_addr(x_mem_addr), .x_denied(x_denied), .erase_page(erase_page), .ram_sel(ram_sel),
        .sfr_sel(sfr_sel), .byte_addr(byte_addr), .bit_pos(bit_pos), .bit_ok(bit_ok),
        .ptr_addr(ptr_addr), .sfr_rdata_q(sfr_rdata_q), .adlo_q(adlo_q), .adlo_oe_q(adlo_oe_q),
        .hw_config_q(hw_config_q));
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_val(logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_tgt(mmd_tgt_t got, mmd_tgt_t exp);
        chk_val({13'h0000, got}, {13'h0000, exp});
    endtask
    task automatic set_cfg(logic [3:0] v, logic pm);
        @(negedge mclk);
        prog_mode_pin = pm;
        repeat (3) @(negedge mclk);
        cfg_we    = 1'h1;
        cfg_wdata = v;
        @(negedge mclk);
        cfg_we        = 1'h0;
        prog_mode_pin = 1'h0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic t_partition();
        logic [15:0] top, dend;
        for (int c = 0; c < 8; c++) begin
            set_cfg({1'h0, 3'(c)}, 1'h1);
            chk_val({12'h000, hw_config_q}, {13'h0000, 3'(c)});
            top  = TOPS[c];
            dend = 16'h0400 + (16'h8000 - top);
            if (top != 16'h0000) begin
                mmd_core_model_i.fetch(top - 16'h0001); #1;
                chk_tgt(fetch_tgt, MMD_T_PFLASH);
            end
            mmd_core_model_i.fetch(top); #1;
            chk_tgt(fetch_tgt, MMD_T_EXT);
            mmd_core_model_i.xmove(1'h0, 1'h0, 16'h03FF, 8'h00); #1;
            chk_tgt(x_tgt, MMD_T_SRAM);
            if (c != 7) begin
                mmd_core_model_i.xmove(1'h0, 1'h0, dend - 16'h0001, 8'h00); #1;
                chk_tgt(x_tgt, MMD_T_DFLASH);
                chk_val(x_mem_addr, dend - 16'h0401);
            end
            mmd_core_model_i.xmove(1'h0, 1'h0, dend, 8'h00); #1;
            chk_tgt(x_tgt, MMD_T_EXT);
        end
        set_cfg(4'h2, 1'h0);
        chk_val({12'h000, hw_config_q}, 16'h0007);
    endtask
    task automatic t_write_lock();
        mmd_core_model_i.reg_req(1'h0, 1'h0, 1'h0, 8'h8F, 1'h1, 8'h01);
        mmd_core_model_i.reg_req(1'h0, 1'h0, 1'h0, 8'h8F, 1'h0, 8'h00);
        @(posedge mclk); #1;
        chk_val({8'h00, sfr_rdata_q}, 16'h0001);
        mmd_core_model_i.xmove(1'h1, 1'h0, 16'h1000, 8'h5A); #1;
        chk_tgt(x_tgt, MMD_T_PFLASH);
        chk_val({15'h0000, x_denied}, 16'h0000);
        set_cfg(4'hF, 1'h1);
        mmd_core_model_i.xmove(1'h1, 1'h0, 16'h1000, 8'h5A); #1;
        chk_val({15'h0000, x_denied}, 16'h0001);
        mmd_core_model_i.reg_req(1'h0, 1'h0, 1'h0, 8'h8F, 1'h1, 8'h00);
        set_cfg(4'hE, 1'h1);
        mmd_core_model_i.xmove(1'h0, 1'h1, 16'h0480, 8'h00); #1;
        chk_val({7'h00, erase_page}, 16'h0009);
        chk_val({15'h0000, x_denied}, 16'h0000);
        mmd_core_model_i.xmove(1'h1, 1'h0, 16'h0480, 8'h3C); #1;
        chk_tgt(x_tgt, MMD_T_DFLASH);
        chk_val({15'h0000, x_denied}, 16'h0000);
    endtask
    task automatic t_port();
        mmd_core_model_i.xmove(1'h1, 1'h0, 16'h9000, 8'hA5);
        @(posedge mclk); #1;
        chk_val({7'h00, adlo_oe_q, adlo_q}, 16'h01A5);
        mmd_core_model_i.xmove(1'h1, 1'h0, 16'h0500, 8'hC3);
        @(posedge mclk); #1;
        chk_val({7'h00, adlo_oe_q, adlo_q}, 16'h0100);
    endtask
    task automatic reg_chk(logic ind, logic bo, logic [7:0] a, logic rs, logic ss, logic [7:0] b, logic [2:0] p);
        mmd_core_model_i.reg_req(ind, bo, 1'h0, a, 1'h0, 8'h00); #1;
        chk_val({ram_sel, sfr_sel, byte_addr}, {6'h00, rs, ss, b});
        if (bo)
            chk_val({bit_ok, bit_pos}, {12'h001, p});
    endtask
    task automatic t_regs();
        reg_chk(1'h0, 1'h0, 8'h7F, 1'h1, 1'h0, 8'h7F, 3'h0);
        reg_chk(1'h0, 1'h0, 8'h80, 1'h0, 1'h1, 8'h80, 3'h0);
        reg_chk(1'h1, 1'h0, 8'h80, 1'h1, 1'h0, 8'h80, 3'h0);
        reg_chk(1'h1, 1'h0, 8'hFF, 1'h1, 1'h0, 8'hFF, 3'h0);
        reg_chk(1'h0, 1'h1, 8'h00, 1'h1, 1'h0, 8'h20, 3'h0);
        reg_chk(1'h0, 1'h1, 8'h7F, 1'h1, 1'h0, 8'h2F, 3'h7);
        reg_chk(1'h0, 1'h0, 8'h20, 1'h1, 1'h0, 8'h20, 3'h0);
        reg_chk(1'h0, 1'h1, 8'h20, 1'h1, 1'h0, 8'h24, 3'h0);
        reg_chk(1'h0, 1'h1, 8'h85, 1'h0, 1'h1, 8'h80, 3'h5);
        reg_chk(1'h0, 1'h1, 8'hD3, 1'h0, 1'h1, 8'hD0, 3'h3);
        for (int b = 0; b < 4; b++) begin
            mmd_core_model_i.reg_req(1'h0, 1'h0, 1'h0, 8'hD0, 1'h1, {3'h0, 2'(b), 3'h0});
            mmd_core_model_i.reg_req(1'h0, 1'h0, 1'h1, 8'h03, 1'h0, 8'h00); #1;
            chk_val({7'h00, ram_sel, byte_addr}, {8'h01, 3'h0, 2'(b), 3'h3});
            chk_val({8'h00, ptr_addr}, {11'h000, 2'(b), 3'h1});
        end
    endtask
    initial begin
        nrst          = 1'h0;
        prog_mode_pin = 1'h0;
        cfg_we        = 1'h0;
        cfg_wdata     = 4'h0;
        repeat (21) @(negedge mclk);
        nrst = 1'h1;
        #1;
        chk_val({hw_config_q, sfr_rdata_q, adlo_q[3:0]}, 16'h7000);
        chk_val({15'h0000, adlo_oe_q}, 16'h0000);
        t_partition();
        t_write_lock();
        t_port();
        t_regs();
        stop_test();
    end
endmodule
